// file: include/supervisor_cfg.svh
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

// Register byte offsets.
`define SUP_CTRL_OFFSET      12'h000
`define SUP_STATUS_OFFSET    12'h004
`define SUP_EVENT_OFFSET     12'h008
`define SUP_REJCNT_OFFSET    12'h00C

// Control register fields and reset value.
`define SUP_CTRL_TSEL_LO     0
`define SUP_CTRL_TSEL_HI     1
`define SUP_CTRL_LOCK_LO     2
`define SUP_CTRL_LOCK_HI     3
`define SUP_CTRL_RESET       4'h0

// Status register fields.
`define SUP_ST_RESET         0
`define SUP_ST_MANUAL        1
`define SUP_ST_PROTECT       2
`define SUP_ST_MON2          3
`define SUP_ST_MON3          4
`define SUP_ST_SDA           5
`define SUP_ST_SUPPLY_LOW    6

// Event register fields, write one to clear.
`define SUP_EV_REJECT        0
`define SUP_EV_ACCEPT        1
`define SUP_EV_WIPER         2

// Reset hold times in microseconds, one per timeout select code.
`define SUP_CLK_HZ           10000000
`define SUP_HOLD_US_0        100
`define SUP_HOLD_US_1        200
`define SUP_HOLD_US_2        400
`define SUP_HOLD_US_3        800
`define SUP_US_CYCLES(t)     ((t) * (`SUP_CLK_HZ / 1000000))

`endif

// file: include/supervisor_pkg.sv
package supervisor_pkg;

   typedef logic [1:0] timeout_sel_t;

   typedef logic [1:0] region_lock_t;

   typedef enum logic [1:0] {
      HOLD_ASSERT,
      HOLD_COUNT,
      HOLD_RELEASED
   } hold_state_t;

endpackage : supervisor_pkg

// file: rtl/reset_stretch_timer.sv
`timescale 1ns/1ps

module reset_stretch_timer #(
   parameter int unsigned CW      = 16,
   parameter int unsigned CYCLES0 = 1000,
   parameter int unsigned CYCLES1 = 2000,
   parameter int unsigned CYCLES2 = 4000,
   parameter int unsigned CYCLES3 = 8000
) (
   // Clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // Reset request and hold time choice
   input  wire logic                        hold,
   input  wire supervisor_pkg::timeout_sel_t sel,
   // Stretched reset
   output logic                             active
);
   import supervisor_pkg::*;

   hold_state_t   state;
   hold_state_t   next_state;
   logic [CW-1:0] count;

   function automatic logic [CW-1:0] hold_cycles(input timeout_sel_t s);
      case (s)
         2'h0:    hold_cycles = CW'(CYCLES0);
         2'h1:    hold_cycles = CW'(CYCLES1);
         2'h2:    hold_cycles = CW'(CYCLES2);
         default: hold_cycles = CW'(CYCLES3);
      endcase
   endfunction : hold_cycles

   always_comb begin
      next_state = state;
      case (state)
         HOLD_ASSERT: begin
            if (!hold) begin
               next_state = HOLD_COUNT;
            end
         end
         HOLD_COUNT: begin
            if (hold) begin
               next_state = HOLD_ASSERT;
            end else if (count <= CW'(1)) begin
               next_state = HOLD_RELEASED;
            end
         end
         HOLD_RELEASED: begin
            if (hold) begin
               next_state = HOLD_ASSERT;
            end
         end
         default: next_state = HOLD_ASSERT;
      endcase
   end

   // Reset leaves the machine asserting, so power-up always stretches.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= HOLD_ASSERT;
      end else begin
         state <= next_state;
      end
   end

   // The choice is taken when counting starts; later changes wait.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (state != HOLD_COUNT) begin
         count <= hold_cycles(sel);
      end else begin
         count <= count - CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= 1'b1;
      end else begin
         active <= (next_state != HOLD_RELEASED);
      end
   end

endmodule : reset_stretch_timer

// file: rtl/supervisor_reset_write_protect.sv
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "supervisor_cfg.svh"

module supervisor_reset_write_protect #(
   parameter int unsigned CW          = 16,
   parameter int unsigned HOLD_CYC_0  = `SUP_US_CYCLES(`SUP_HOLD_US_0),
   parameter int unsigned HOLD_CYC_1  = `SUP_US_CYCLES(`SUP_HOLD_US_1),
   parameter int unsigned HOLD_CYC_2  = `SUP_US_CYCLES(`SUP_HOLD_US_2),
   parameter int unsigned HOLD_CYC_3  = `SUP_US_CYCLES(`SUP_HOLD_US_3),
   parameter int unsigned REJ_W       = 16
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Supervisor pins and comparator results
   input  wire logic        manual_reset_in,
   input  wire logic        supply_low,
   input  wire logic        monitor2_input,
   input  wire logic        monitor3_input,
   output logic             supply_reset_out,
   output logic             supply_reset_oe,
   output logic             monitor2_fail_out,
   output logic             monitor2_fail_oe,
   output logic             monitor3_fail_out,
   output logic             monitor3_fail_oe,
   // Write gate towards the serial protocol engine
   input  wire logic        write_protect_in,
   input  wire logic        sda_in,
   output logic             sda_seen,
   input  wire logic        wr_req,
   input  wire logic        wr_nonvolatile,
   input  wire logic        wr_wiper,
   output logic             wr_accept,
   output logic             wr_reject
);
   import supervisor_pkg::*;

   // Control register state.
   timeout_sel_t      tsel;
   region_lock_t      lock;

   // Synchronisers and sampled pins.
   logic              mr_meta;
   logic              mr_sync;
   logic              wp_level;

   // Stretched reset from the hold timer.
   logic              timer_active;

   // Sticky events and reject counter.
   logic              ev_reject;
   logic              ev_accept;
   logic              ev_wiper;
   logic [REJ_W-1:0]  rej_count;
   logic              wr_blocked;

   // APB decode.
   logic              setup;
   logic              access;
   logic              wr_en;
   logic [31:0]       next_prdata;
   logic              next_pslverr;

   function automatic logic is_mapped(input logic [11:0] a);
      case (a)
         `SUP_CTRL_OFFSET,
         `SUP_STATUS_OFFSET,
         `SUP_EVENT_OFFSET,
         `SUP_REJCNT_OFFSET: is_mapped = 1'b1;
         default:            is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   function automatic logic blocks_write(input logic wp,
                                         input region_lock_t lk,
                                         input logic nv);
      blocks_write = wp && (nv || (lk != 2'h0));
   endfunction : blocks_write

   // True when this access writes a one to the given event bit.
   function automatic logic clears_event(input logic        we,
                                         input logic [11:0] a,
                                         input logic [31:0] d,
                                         input int unsigned b);
      clears_event = we && (a == `SUP_EVENT_OFFSET) && d[b];
   endfunction : clears_event

   assign setup  = psel && !penable;
   assign access = psel && penable && pready;
   assign wr_en  = access && pwrite && !pslverr;

   // Manual reset passes two flops before anything else sees it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mr_meta <= 1'b0;
         mr_sync <= 1'b0;
      end else begin
         mr_meta <= manual_reset_in;
         mr_sync <= mr_meta;
      end
   end

   // The pad pull-down makes a floating pin read low; reset also clears it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_level <= 1'b0;
      end else begin
         wp_level <= write_protect_in;
      end
   end

   // The receiver has no enable: every edge on the line is sampled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_seen <= 1'b1;
      end else begin
         sda_seen <= sda_in;
      end
   end

   reset_stretch_timer #(
      .CW      (CW),
      .CYCLES0 (HOLD_CYC_0),
      .CYCLES1 (HOLD_CYC_1),
      .CYCLES2 (HOLD_CYC_2),
      .CYCLES3 (HOLD_CYC_3)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .hold    (mr_sync || supply_low),
      .sel     (tsel),
      .active  (timer_active)
   );

   // Open-drain active-high reset: the pad is pulled low only when idle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_reset_out <= 1'b1;
      end else begin
         supply_reset_out <= supply_low || mr_sync || timer_active;
      end
   end

   // While reset is asserted the pad is released and its pull-up lifts it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_reset_oe <= 1'b0;
      end else begin
         supply_reset_oe <= !(supply_low || mr_sync || timer_active);
      end
   end

   // Fail outputs carry no stretch; one register stage only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         monitor2_fail_out <= 1'b0;
      end else begin
         monitor2_fail_out <= monitor2_input;
      end
   end

   // While monitor2_input reports a fail the pad is released and its pull-up lifts it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         monitor2_fail_oe <= 1'b1;
      end else begin
         monitor2_fail_oe <= !monitor2_input;
      end
   end

   // Monitor three behaves the same, against its own trip level.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         monitor3_fail_out <= 1'b0;
      end else begin
         monitor3_fail_out <= monitor3_input;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         monitor3_fail_oe <= 1'b1;
      end else begin
         monitor3_fail_oe <= !monitor3_input;
      end
   end

   // Wiper updates are volatile writes and fall under the lock check.
   assign wr_blocked = blocks_write(wp_level, lock,
                                    wr_nonvolatile);

   // Exactly one answer follows each request, one cycle later.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_accept <= 1'b0;
      end else begin
         wr_accept <= wr_req && !wr_blocked;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_reject <= 1'b0;
      end else begin
         wr_reject <= wr_req && wr_blocked;
      end
   end

   // Lock and select share one word so software sets both at once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {lock, tsel} <= `SUP_CTRL_RESET;
      end else if (wr_en && paddr == `SUP_CTRL_OFFSET) begin
         tsel <= pwdata[`SUP_CTRL_TSEL_HI:`SUP_CTRL_TSEL_LO];
         lock <= pwdata[`SUP_CTRL_LOCK_HI:`SUP_CTRL_LOCK_LO];
      end
   end

   // A new event in the clearing cycle wins over the clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_reject <= 1'b0;
      end else if (wr_reject) begin
         ev_reject <= 1'b1;
      end else if (clears_event(wr_en, paddr, pwdata, `SUP_EV_REJECT)) begin
         ev_reject <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_accept <= 1'b0;
      end else if (wr_accept) begin
         ev_accept <= 1'b1;
      end else if (clears_event(wr_en, paddr, pwdata, `SUP_EV_ACCEPT)) begin
         ev_accept <= 1'b0;
      end
   end

   // Only refused wiper updates are recorded; the wiper sits outside.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_wiper <= 1'b0;
      end else if (wr_req && wr_wiper && wr_blocked) begin
         ev_wiper <= 1'b1;
      end else if (clears_event(wr_en, paddr, pwdata, `SUP_EV_WIPER)) begin
         ev_wiper <= 1'b0;
      end
   end

   // The counter saturates so a flood of rejects never wraps to zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rej_count <= '0;
      end else if (wr_reject && !(&rej_count)) begin
         rej_count <= rej_count + REJ_W'(1);
      end
   end

   // Read data is built at setup so it stands ready in the access phase.
   always_comb begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = !is_mapped(paddr);
      case (paddr)
         `SUP_CTRL_OFFSET: begin
            next_prdata[`SUP_CTRL_TSEL_HI:`SUP_CTRL_TSEL_LO] = tsel;
            next_prdata[`SUP_CTRL_LOCK_HI:`SUP_CTRL_LOCK_LO] = lock;
         end
         `SUP_STATUS_OFFSET: begin
            next_prdata[`SUP_ST_RESET]      = supply_reset_out;
            next_prdata[`SUP_ST_MANUAL]     = mr_sync;
            next_prdata[`SUP_ST_PROTECT]    = wp_level;
            next_prdata[`SUP_ST_MON2]       = monitor2_fail_out;
            next_prdata[`SUP_ST_MON3]       = monitor3_fail_out;
            next_prdata[`SUP_ST_SDA]        = sda_seen;
            next_prdata[`SUP_ST_SUPPLY_LOW] = supply_low;
         end
         `SUP_EVENT_OFFSET: begin
            next_prdata[`SUP_EV_REJECT] = ev_reject;
            next_prdata[`SUP_EV_ACCEPT] = ev_accept;
            next_prdata[`SUP_EV_WIPER]  = ev_wiper;
         end
         `SUP_REJCNT_OFFSET: begin
            next_prdata[REJ_W-1:0] = rej_count;
         end
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   // One access cycle: pready rises on the first access-phase edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // Read data is zero outside read accesses so stale words never show.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= next_prdata;
      end else begin
         prdata <= 32'h0000_0000;
      end
   end

   // The error flag qualifies only the access cycle of an unmapped address.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup && next_pslverr;
      end
   end

endmodule : supervisor_reset_write_protect

// file: verif/board_model.sv
`timescale 1ns/1ps
module board_model (
   // Open-drain enables from the supervisor
   input  wire logic supply_reset_oe,
   input  wire logic monitor2_fail_oe,
   input  wire logic monitor3_fail_oe,
   // Write-protect strap as the host wires it
   input  wire logic wp_drive,
   input  wire logic wp_float,
   // Levels seen on the board
   output logic      reset_pin,
   output logic      mon2_pin,
   output logic      mon3_pin,
   output logic      write_protect_in
);
   // Pull-ups lift each open-drain line whenever nobody pulls it low.
   assign reset_pin = !supply_reset_oe;
   assign mon2_pin = !monitor2_fail_oe;
   assign mon3_pin = !monitor3_fail_oe;
   // A floating strap is held low by its pull-down, so protection is off.
   assign write_protect_in = wp_float ? 1'b0 : wp_drive;
endmodule : board_model

// file: verif/supervisor_chk.sv
`timescale 1ns/1ps
module supervisor_chk #(
   parameter int unsigned HOLD_CYC_0 = 1000
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Supervisor pins
   input wire logic manual_reset_in,
   input wire logic supply_low,
   input wire logic monitor2_input,
   input wire logic monitor3_input,
   input wire logic supply_reset_out,
   input wire logic monitor2_fail_out,
   input wire logic monitor2_fail_oe,
   input wire logic monitor3_fail_out,
   input wire logic monitor3_fail_oe,
   // Write gate
   input wire logic write_protect_in,
   input wire logic sda_in,
   input wire logic sda_seen,
   input wire logic wr_req,
   input wire logic wr_nonvolatile,
   input wire logic wr_accept,
   input wire logic wr_reject
);
   // Cycles since both reset causes went quiet, saturating.
   int unsigned quiet;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet <= 0;
      end else if (manual_reset_in || supply_low) begin
         quiet <= 0;
      end else if (quiet < 1000) begin
         quiet <= quiet + 1;
      end
   end
   supply_trip_a: assert property (supply_low |=> supply_reset_out)
      else $error("supply reset not raised while supply low");
   manual_start_a: assert property (
      manual_reset_in [*3] |=> supply_reset_out)
      else $error("manual reset did not raise supply reset");
   hold_time_a: assert property (
      $fell(supply_reset_out) |-> quiet >= HOLD_CYC_0)
      else $error("supply reset released before hold time");
   mon2_follow_a: assert property (
      monitor2_fail_out == $past(monitor2_input)
      && monitor2_fail_oe != monitor2_fail_out)
      else $error("monitor two fail output wrong");
   mon3_follow_a: assert property (
      monitor3_fail_out == $past(monitor3_input)
      && monitor3_fail_oe != monitor3_fail_out)
      else $error("monitor three fail output wrong");
   sda_live_a: assert property (sda_seen == $past(sda_in))
      else $error("serial data receiver not following line");
   gate_pair_a: assert property (wr_req |=> wr_accept ^ wr_reject)
      else $error("write request without single answer");
   wp_nvol_a: assert property (
      wr_req && wr_nonvolatile && $past(write_protect_in) |=> wr_reject)
      else $error("nonvolatile write accepted under protection");
   wp_off_a: assert property (
      wr_req && !$past(write_protect_in) |=> wr_accept)
      else $error("write refused without protection");
   cover property ($fell(supply_reset_out));
   cover property (wr_req ##1 wr_reject);
   cover property (manual_reset_in [*3]);
endmodule : supervisor_chk

bind supervisor_reset_write_protect supervisor_chk #(
   .HOLD_CYC_0(HOLD_CYC_0)
) i_supervisor_chk (
   .pclk, .presetn, .manual_reset_in, .supply_low, .monitor2_input,
   .monitor3_input, .supply_reset_out, .monitor2_fail_out, .monitor2_fail_oe,
   .monitor3_fail_out, .monitor3_fail_oe, .write_protect_in, .sda_in,
   .sda_seen, .wr_req, .wr_nonvolatile, .wr_accept, .wr_reject
);

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   import supervisor_pkg::*;
   // Hold times spread wide so a wrong select code cannot pass unseen.
   localparam int unsigned H [4] = '{5, 15, 25, 35};
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, err;
   logic        manual_reset_in = 1'b0, supply_low = 1'b0;
   logic        monitor2_input = 1'b0, monitor3_input = 1'b0;
   logic        sda_in = 1'b1, wr_req = 1'b0, wr_nonvolatile = 1'b0;
   logic        wr_wiper = 1'b0, wp_drive = 1'b0, wp_float = 1'b1;
   logic        supply_reset_out, supply_reset_oe, monitor2_fail_out;
   logic        monitor2_fail_oe, monitor3_fail_out, monitor3_fail_oe;
   logic        sda_seen, wr_accept, wr_reject, write_protect_in;
   logic        reset_pin, mon2_pin, mon3_pin;
   int          fail_count = 0, checks = 0, cycles = 0;

   supervisor_reset_write_protect #(
      .HOLD_CYC_0(H[0]), .HOLD_CYC_1(H[1]), .HOLD_CYC_2(H[2]),
      .HOLD_CYC_3(H[3])
   ) i_supervisor_reset_write_protect (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .manual_reset_in, .supply_low, .monitor2_input,
      .monitor3_input, .supply_reset_out, .supply_reset_oe,
      .monitor2_fail_out, .monitor2_fail_oe, .monitor3_fail_out,
      .monitor3_fail_oe, .write_protect_in, .sda_in, .sda_seen, .wr_req,
      .wr_nonvolatile, .wr_wiper, .wr_accept, .wr_reject
   );
   board_model i_board_model (
      .supply_reset_oe, .monitor2_fail_oe, .monitor3_fail_oe, .wp_drive,
      .wp_float, .reset_pin, .mon2_pin, .mon3_pin, .write_protect_in
   );

   always #50 pclk = ~pclk;

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   // Long enough for every test several times over.
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Counts cycles until the supply reset drops, then judges the span.
   task automatic measure(input int unsigned n, input string msg);
      int unsigned t;
      t = 0;
      while (supply_reset_out === 1'b1 && t < 100) begin
         @(negedge pclk);
         t++;
      end
      chk(32'(t >= n && t <= n + 5), 32'h0000_0001, msg);
   endtask : measure

   task automatic wreq(input logic nv, input logic rej, input string msg);
      @(posedge pclk);
      wr_req <= 1'b1;
      wr_nonvolatile <= nv;
      wr_wiper <= ~nv;
      @(posedge pclk);
      wr_req <= 1'b0;
      @(negedge pclk);
      chk(32'({wr_accept, wr_reject}), 32'({~rej, rej}), msg);
   endtask : wreq

   task automatic t_regs();
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "control reset value");
      apb(1'b1, 12'h000, 32'h0000_000A);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_000A, "control read back");
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001, "unmapped address error");
   endtask : t_regs

   task automatic t_manual();
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, 12'h000, 32'(s));
         @(posedge pclk);
         manual_reset_in <= 1'b1;
         repeat (4) @(posedge pclk);
         @(negedge pclk);
         chk(32'(reset_pin), 32'h0000_0001, "manual reset start");
         @(posedge pclk);
         manual_reset_in <= 1'b0;
         measure(H[s] + 2, "manual reset hold");
      end
   endtask : t_manual

   task automatic t_supply();
      @(posedge pclk);
      supply_low <= 1'b1;
      @(posedge pclk);
      @(negedge pclk);
      chk(32'(supply_reset_out), 32'h0000_0001, "supply low reset");
      repeat (5) @(posedge pclk);
      supply_low <= 1'b0;
      measure(H[3] + 1, "supply recovery hold");
   endtask : t_supply

   task automatic t_monitors();
      for (int v = 0; v < 4; v++) begin
         @(posedge pclk);
         monitor2_input <= v[0];
         monitor3_input <= v[1];
         @(posedge pclk);
         @(negedge pclk);
         chk(32'(mon2_pin), 32'(v[0]), "monitor two fail");
         chk(32'(mon3_pin), 32'(v[1]), "monitor three fail");
      end
   endtask : t_monitors

   task automatic t_writes();
      @(posedge pclk);
      wp_drive <= 1'b1;
      wreq(1'b1, 1'b0, "floating protect pin");
      @(posedge pclk);
      wp_drive <= 1'b0;
      wp_float <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         @(posedge pclk);
         wp_drive <= i[0];
         apb(1'b1, 12'h000, 32'({i[3:2], 2'b00}));
         wreq(i[1], i[0] & (i[1] | (i[3:2] != 2'b00)),
              "write gate");
      end
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0007, "write events");
      apb(1'b1, 12'h008, 32'h0000_0007);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "write events cleared");
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk(rd, 32'h0000_0007, "reject count");
   endtask : t_writes

   task automatic t_sda();
      @(posedge pclk);
      sda_in <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      chk(32'(sda_seen), 32'h0000_0000, "serial data seen");
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(rd, 32'h0000_001C, "status bits");
   endtask : t_sda

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      measure(H[0] + 1, "power-up hold");
      $display("power-up test done");
      t_regs();
      $display("register test done");
      t_manual();
      $display("manual reset test done");
      t_supply();
      $display("supply test done");
      t_monitors();
      $display("monitor test done");
      t_writes();
      $display("write gate test done");
      t_sda();
      $display("serial data test done");
      finish_test();
   end
endmodule : testbench
